// file: rtl/pks_pkg.sv
/*
  pks_pkg: shared constants and types of the panel knob stage selector.
  Assumes a 200 MHz system clock and a 32-bit AHB-Lite register bus.
*/
package pks_pkg;
  // clock and time figures
  localparam int CLK_MHZ = 200;
  localparam int HOLD_TIME_MS = 2000;
  localparam int HOLD_CYCLES = HOLD_TIME_MS * 1000 * CLK_MHZ;
  localparam int BLINK_TIME_MS = 250;
  localparam int BLINK_CYCLES = BLINK_TIME_MS * 1000 * CLK_MHZ;
  localparam int CNT_W = 29;

  // register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_GAIN0 = 8'h08;
  localparam int NUM_GAIN = 6;
  localparam int STAGES = 3;
  localparam logic [2:0] HSIZE_WORD = 3'h2;

  // reset values
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] GAIN_RST = 8'h00;
  localparam logic [1:0] STAGE_CNT_THREE = 2'h3;

  typedef enum logic [1:0] {
    MD_IDLE = 2'b00,
    MD_INPUT = 2'b01,
    MD_STAGE = 2'b11
  } pks_mode_t;

  typedef enum logic [1:0] {
    RING_GREEN = 2'b00,
    RING_ORANGE = 2'b01,
    RING_AMBER = 2'b10
  } pks_ring_t;

  // control register layout, bit 7 downward
  typedef struct packed {
    logic [1:0] stage_cnt2;
    logic [1:0] stage_cnt1;
    logic reserved;
    logic link;
    logic [1:0] emu;
  } pks_ctrl_t;

  // status register layout, bit 9 downward
  typedef struct packed {
    logic led2;
    logic led1;
    pks_ring_t ring;
    logic [1:0] stage;
    logic stage_ch;
    logic stage_mode;
    logic sel_ch;
    logic input_mode;
  } pks_status_t;
endpackage

// file: rtl/pks_press.sv
/*
  pks_press: synchronises one push-button pin and classifies presses.
  Assumes a clean (externally debounced) active-high button level.
*/
`timescale 1ns/1ps
`default_nettype none
module pks_press
  import pks_pkg::*;
#(
  parameter int HOLD = HOLD_CYCLES
) (
  input wire logic clk,         // system clock
  input wire logic reset_n,     // sync reset, active low
  input wire logic btn,         // raw button pin
  output logic press,           // pulse at press start
  output logic short_rel,       // pulse at release before hold
  output logic hold             // pulse once when hold time reached
);
  logic sync1, sync2, level;
  logic [CNT_W-1:0] count;
  logic held;

  // two-flop synchroniser, then a delayed copy for edges
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      sync1 <= 1'b0;
      sync2 <= 1'b0;
      level <= 1'b0;
    end else begin
      sync1 <= btn;
      sync2 <= sync1;
      level <= sync2;
    end
  end

  // hold timer; saturates so a very long hold fires once
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      count <= '0;
      held <= 1'b0;
      press <= 1'b0;
      short_rel <= 1'b0;
      hold <= 1'b0;
    end else begin
      press <= sync2 & ~level;
      short_rel <= ~sync2 & level & ~held;
      hold <= 1'b0;
      if (!sync2) begin
        count <= '0;
        held <= 1'b0;
      end else if (!held) begin
        if (count == CNT_W'(HOLD - 1)) begin
          held <= 1'b1;
          hold <= 1'b1;
        end else begin
          count <= count + 1'b1;
        end
      end
    end
  end
endmodule
`default_nettype wire

// file: rtl/pks_blink.sv
/*
  pks_blink: divider giving the flashing level for indicator leds.
  Assumes the system clock; free running from reset.
*/
`timescale 1ns/1ps
`default_nettype none
module pks_blink
  import pks_pkg::*;
#(
  parameter int HALF = BLINK_CYCLES
) (
  input wire logic clk,      // system clock
  input wire logic reset_n,  // sync reset, active low
  output logic flash         // square wave, HALF cycles per phase
);
  logic [CNT_W-1:0] count;

  // count up half a period, then flip the level
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      count <= '0;
      flash <= 1'b0;
    end else if (count == CNT_W'(HALF - 1)) begin
      count <= '0;
      flash <= ~flash;
    end else begin
      count <= count + 1'b1;
    end
  end
endmodule
`default_nettype wire

// file: rtl/pks_top.sv
/*
  pks_top: front-panel channel and gain stage selection with an AHB-Lite
  register slave. Host software reports emulation state, stage count and
  stereo link through the control register and mirrors gains through the
  gain registers. Assumes button and rotary step pins are asynchronous.
*/
// The register addresses and the AHB-Lite interface to the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none

// Contract
// - panel and plug-in gains stay mirrored
// - emulation on selected channel lights ring orange
// - emulation start controls first gain stage
// - emulation disabled returns ring to green
// - input button toggles channel after input mode
// - knob press toggles channel in channel mode
// - selected led lit, both when linked
// - two second hold enters stage mode
// - stage mode on one channel at most
// - short press cycles two or three stages
// - stage mode flashes selected channel led; when linked both leds stay steady lit instead
// - two second hold in stage mode leaves
// - plug-in disabled or removed leaves stage mode
// - input button channel change ends stage mode
// - leaving: knob toggles, led stops flashing
// - leaving returns to first stage, orange
// - ring colour orange, amber, green per stage
// - host marks controlled stage matching ring
module pks_top
  import pks_pkg::*;
#(
  parameter int HOLD = HOLD_CYCLES,
  parameter int BLINK_HALF = BLINK_CYCLES
) (
  input wire logic clk,               // system clock, 200 MHz
  input wire logic reset_n,           // sync reset, active low
  input wire logic hsel,              // slave select
  input wire logic [7:0] haddr,       // byte address
  input wire logic [1:0] htrans,      // transfer type
  input wire logic hwrite,            // write when high
  input wire logic [2:0] hsize,       // transfer size
  input wire logic [31:0] hwdata,     // write data
  input wire logic hready,            // bus ready
  output logic hreadyout,             // slave ready
  output logic hresp,                 // always okay
  output logic [31:0] hrdata,         // read data
  input wire logic input_btn,         // input-adjust button pin
  input wire logic knob_btn,          // level knob push pin
  input wire logic knob_inc,          // knob step up pin
  input wire logic knob_dec,          // knob step down pin
  output logic first_channel_indicator,   // channel one led
  output logic second_channel_indicator,  // channel two led
  output pks_ring_t ring              // knob ring colour
);
  logic inp_press, knob_short, knob_hold;
  logic flash;
  pks_ctrl_t ctrl;
  pks_mode_t mode;
  logic sel_ch;
  logic stage_ch;
  logic [1:0] stage [2];
  logic [1:0] emu_q;
  logic [7:0] gain [NUM_GAIN];
  logic [2:0] inc_s, dec_s;
  logic step_up, step_dn;
  logic wr_pend;
  logic [7:0] wr_addr;
  logic acc;
  logic [31:0] wdata_now;
  pks_status_t status;
  logic [31:0] next_hrdata;

  pks_press #(
    .HOLD(HOLD)
  ) u_inp (
    .clk(clk),
    .reset_n(reset_n),
    .btn(input_btn),
    .press(inp_press),
    .short_rel(),
    .hold()
  );

  pks_press #(
    .HOLD(HOLD)
  ) u_knob (
    .clk(clk),
    .reset_n(reset_n),
    .btn(knob_btn),
    .press(),
    .short_rel(knob_short),
    .hold(knob_hold)
  );

  pks_blink #(
    .HALF(BLINK_HALF)
  ) u_blink (
    .clk(clk),
    .reset_n(reset_n),
    .flash(flash)
  );

  // last stage index the plug-in on a channel provides
  function automatic logic [1:0] last_stage(input logic [1:0] cnt);
    last_stage = (cnt == STAGE_CNT_THREE) ? 2'h2 : 2'h1;
  endfunction

  // gain register index for a channel and stage
  function automatic logic [2:0] gain_idx(input logic ch, input logic [1:0] stg);
    gain_idx = ch ? (3'(STAGES) + {1'b0, stg}) : {1'b0, stg};
  endfunction

  // aligned address inside the gain window
  function automatic logic gain_hit(input logic [7:0] a);
    gain_hit = (a >= OFS_GAIN0) && (a < OFS_GAIN0 + 8'(4 * NUM_GAIN)) && (a[1:0] == 2'h0);
  endfunction

  // gain word index of an address already known to hit the window
  function automatic logic [2:0] gain_word(input logic [7:0] a);
    logic [7:0] rel;
    rel = a - OFS_GAIN0;
    gain_word = rel[4:2];
  endfunction

  // words the host may write; status and holes never take a write
  function automatic logic host_writable(input logic [7:0] a);
    host_writable = (a == OFS_CTRL) || gain_hit(a);
  endfunction

  // stage count field that belongs to a channel
  function automatic logic [1:0] stage_cnt_of(input pks_ctrl_t c, input logic ch);
    stage_cnt_of = ch ? c.stage_cnt2 : c.stage_cnt1;
  endfunction

  // ring colour of a controlled stage; a third stage is the clean output
  function automatic pks_ring_t stage_colour(input logic [1:0] stg);
    case (stg)
      2'h0: stage_colour = RING_ORANGE;
      2'h1: stage_colour = RING_AMBER;
      default: stage_colour = RING_GREEN;
    endcase
  endfunction

  // bus decode of the address phase
  assign acc = hsel & htrans[1] & hready;
  assign wdata_now = hwdata;

  // rotary step pins: two-flop sync then edge copy
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      inc_s <= 3'h0;
      dec_s <= 3'h0;
    end else begin
      inc_s <= {inc_s[1:0], knob_inc};
      dec_s <= {dec_s[1:0], knob_dec};
    end
  end
  assign step_up = inc_s[1] & ~inc_s[2];
  assign step_dn = dec_s[1] & ~dec_s[2];

  // address phase capture; only whole-word writes are stored
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
    end else begin
      wr_pend <= acc & hwrite & (hsize == HSIZE_WORD);
      wr_addr <= haddr;
    end
  end

  // control register, written by the host only
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      ctrl <= pks_ctrl_t'(CTRL_RST);
    end else if (wr_pend && wr_addr == OFS_CTRL) begin
      ctrl <= pks_ctrl_t'(wdata_now[7:0]);
    end
  end

  // previous emulation flags for start and stop edges
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      emu_q <= 2'h0;
    end else begin
      emu_q <= ctrl.emu;
    end
  end

  // panel mode machine: idle, input, stage-cycle
  // a hold acts once at the threshold and its release is not a short press,
  // so one long push never both changes mode and toggles the channel
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      mode <= MD_IDLE;
      sel_ch <= 1'b0;
      stage_ch <= 1'b0;
    end else begin
      case (mode)
        MD_IDLE: begin
          if (inp_press) begin
            mode <= MD_INPUT;
          end
        end
        MD_INPUT: begin
          if (inp_press) begin
            sel_ch <= ~sel_ch;
          end else if (knob_hold && ctrl.emu[sel_ch]) begin
            mode <= MD_STAGE;
            stage_ch <= sel_ch; // single owner flag
          end else if (knob_short) begin
            sel_ch <= ~sel_ch;
          end
        end
        MD_STAGE: begin
          if (!ctrl.emu[stage_ch]) begin
            mode <= MD_INPUT;
          end else if (inp_press) begin
            sel_ch <= ~sel_ch;
            mode <= MD_INPUT;
          end else if (knob_hold) begin
            mode <= MD_INPUT;
          end
        end
        default: begin
          mode <= MD_IDLE;
        end
      endcase
    end
  end

  // controlled stage per channel
  // only the stage-mode channel ever leaves stage one, which simple
  for (genvar c = 0; c < 2; c++) begin : g_stage
    always_ff @(posedge clk) begin
      if (!reset_n) begin
        stage[c] <= 2'h0;
      end else if (ctrl.emu[c] != emu_q[c]) begin
        stage[c] <= 2'h0;
      end else if (mode != MD_STAGE || stage_ch != 1'(c)) begin
        stage[c] <= 2'h0; // back to first stage on leaving
      end else if (knob_short) begin
        if (stage[c] >= last_stage(stage_cnt_of(ctrl, 1'(c)))) begin
          stage[c] <= 2'h0;
        end else begin
          stage[c] <= stage[c] + 2'h1;
        end
      end
    end
  end

  // gain mirror: host writes win over a knob step in the same cycle
  for (genvar g = 0; g < NUM_GAIN; g++) begin : g_gain
    always_ff @(posedge clk) begin
      if (!reset_n) begin
        gain[g] <= GAIN_RST;
      end else if (wr_pend && wr_addr == OFS_GAIN0 + 8'(4 * g)) begin
        gain[g] <= wdata_now[7:0]; // plug-in change reaches panel
      end else if (mode != MD_IDLE && gain_idx(sel_ch, stage[sel_ch]) == 3'(g)) begin
        if (step_up && gain[g] != 8'hff) begin
          gain[g] <= gain[g] + 8'h01; // panel change reaches plug
        end else if (step_dn && gain[g] != 8'h00) begin
          gain[g] <= gain[g] - 8'h01;
        end
      end
    end
  end

  // ring colour; green unless input mode on an emulated channel
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      ring <= RING_GREEN;
    end else if (mode == MD_IDLE || !ctrl.emu[sel_ch]) begin
      ring <= RING_GREEN;
    end else begin
      ring <= stage_colour(stage[sel_ch]);
    end
  end

  // channel leds; flashing only while stage mode owns the selection
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      first_channel_indicator <= 1'b0;
      second_channel_indicator <= 1'b0;
    end else if (ctrl.link) begin
      first_channel_indicator <= 1'b1;
      second_channel_indicator <= 1'b1;
    end else if (mode == MD_STAGE && stage_ch == sel_ch) begin
      first_channel_indicator <= ~sel_ch & flash;
      second_channel_indicator <= sel_ch & flash;
    end else begin
      first_channel_indicator <= ~sel_ch; // steady once out of stage mode
      second_channel_indicator <= sel_ch;
    end
  end

  // status word the host uses to place its matching dot
  always_comb begin
    status.led2 = second_channel_indicator;
    status.led1 = first_channel_indicator;
    status.ring = ring;
    status.stage = stage[sel_ch];
    status.stage_ch = stage_ch;
    status.stage_mode = (mode == MD_STAGE);
    status.sel_ch = sel_ch;
    status.input_mode = (mode != MD_IDLE);
  end

  // read word for the address phase on the bus; a write still in its data
  // phase is forwarded so a read straight after it sees the new value, but
  // only for writable words, so status and holes never echo write data
  always_comb begin
    next_hrdata = 32'h0;
    if (wr_pend && wr_addr == haddr && host_writable(haddr)) begin
      next_hrdata = {24'h0, wdata_now[7:0]};
    end else if (haddr == OFS_CTRL) begin
      next_hrdata = {24'h0, ctrl};
    end else if (haddr == OFS_STATUS) begin
      next_hrdata = {22'h0, status};
    end else if (gain_hit(haddr)) begin
      next_hrdata = {24'h0, gain[gain_word(haddr)]};
    end
  end

  // bus response; zero wait states, so hreadyout never drops
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  // read data registered in the address phase; holds until the next read
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      hrdata <= 32'h0;
    end else if (acc && !hwrite) begin
      hrdata <= next_hrdata;
    end
  end
endmodule
`default_nettype wire

// file: test/pks_checker_assertions.sv
/*
  pks_checker: port-level properties of pks_top, bound to every instance.
  Assumes hreadyout is fed back as hready and a single bus master.
*/
`timescale 1ns/1ps
`default_nettype none
module pks_checker
  import pks_pkg::*;
(
  input wire logic clk,                       // system clock
  input wire logic reset_n,                   // sync reset, active low
  input wire logic hsel,                      // slave select
  input wire logic [7:0] haddr,               // byte address
  input wire logic [1:0] htrans,              // transfer type
  input wire logic hwrite,                    // write flag
  input wire logic [2:0] hsize,               // transfer size
  input wire logic [31:0] hwdata,             // write data
  input wire logic hready,                    // bus ready
  input wire logic hreadyout,                 // slave ready
  input wire logic hresp,                     // response
  input wire logic [31:0] hrdata,             // read data
  input wire logic first_channel_indicator,   // channel one led
  input wire logic second_channel_indicator,  // channel two led
  input wire pks_ring_t ring                  // ring colour
);
  logic ap_wr, ap_rd, ap_word;
  logic [7:0] ap_addr, ctrl_q;
  // address phase capture, so data phase checks know what was asked
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      ap_wr <= 1'b0;
      ap_rd <= 1'b0;
      ap_word <= 1'b0;
      ap_addr <= 8'h00;
    end else if (hready) begin
      ap_wr <= hsel && htrans[1] && hwrite;
      ap_rd <= hsel && htrans[1] && !hwrite;
      ap_word <= hsize == HSIZE_WORD;
      ap_addr <= haddr;
    end
  end
  // shadow of the host control word; only link and emulation bits matter
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      ctrl_q <= CTRL_RST;
    end else if (hready && ap_wr && ap_word && ap_addr == OFS_CTRL) begin
      ctrl_q <= hwdata[7:0];
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  sequence s_rd_hole;
    ap_rd && ap_addr >= 8'h20;
  endsequence
  sequence s_linked;
    ctrl_q[2] [*3];
  endsequence
  sequence s_no_emu;
    (ctrl_q[1:0] == 2'b00 && !ctrl_q[2]) [*3];
  endsequence
  a_ready_high: assert property (hreadyout) else $error("slave not ready");
  a_resp_okay: assert property (!hresp) else $error("error response");
  a_ring_code: assert property (ring != 2'b11) else $error("ring code unused");
  a_hole_zero: assert property (s_rd_hole |-> hrdata == 32'h0) else $error("unmapped read not zero");
  a_rdata_upper: assert property (ap_rd |-> hrdata[31:10] == 22'h0) else $error("upper read bits set");
  a_link_both: assert property (s_linked |-> first_channel_indicator && second_channel_indicator)
    else $error("link without both leds");
  a_one_led: assert property (s_no_emu |-> first_channel_indicator != second_channel_indicator)
    else $error("not exactly one led");
  a_green_noemu: assert property (s_no_emu |-> ring == RING_GREEN) else $error("ring not green");
  a_amber_order: assert property (ring == RING_AMBER && $past(ring) != RING_AMBER |->
    $past(ring) == RING_ORANGE) else $error("amber not after orange");
endmodule
bind pks_top pks_checker u_pks_checker (.clk(clk), .reset_n(reset_n), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
  .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .ring(ring),
  .first_channel_indicator(first_channel_indicator), .second_channel_indicator(second_channel_indicator));
`default_nettype wire

// file: test/pks_host_model.sv
/*
  pks_host_model: host software side, an AHB-Lite master of single words.
  Assumes one slave whose hreadyout comes back as hready.
*/
`timescale 1ns/1ps
`default_nettype none
module pks_host_model
  import pks_pkg::*;
(
  input wire logic clk,      // system clock
  input wire logic hready,   // bus ready
  output logic hsel,         // slave select
  output logic [7:0] haddr,  // byte address
  output logic [1:0] htrans, // transfer type
  output logic hwrite,       // write flag
  output logic [2:0] hsize,  // transfer size
  output logic [31:0] hwdata,// write data
  output logic hung          // a wait ran out
);
  initial begin
    hsel = 1'b0;
    haddr = 8'h00;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = HSIZE_WORD;
    hwdata = 32'h0;
    hung = 1'b0;
  end
  // wait for hready at a rising edge; bounded so a dead slave ends the run
  task automatic wait_ready();
    int n;
    n = 0;
    @(posedge clk);
    while (!hready && n < 64) begin
      n++;
      @(posedge clk);
    end
    if (!hready) hung <= 1'b1;
  endtask
  // address phase, then data phase; data inverted when not valid
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= wr;
    wait_ready();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wr ? d : ~hwdata;
    wait_ready();
    hwdata <= ~hwdata;
  endtask
  // host reports emulation, link and stage counts
  task automatic set_ctrl(input logic [7:0] v);
    xfer(1'b1, OFS_CTRL, {24'h0, v});
    repeat (3) @(posedge clk); // mode, then ring and leds follow the new word
  endtask
endmodule
`default_nettype wire

// file: test/panel_knob_stage_selector_test.sv
/*
  panel_knob_stage_selector_test: self-checking bench for pks_top.
  Assumes short hold and flash counts and clean button levels.
*/
`timescale 1ns/1ps
`default_nettype none
module panel_knob_stage_selector_test
  import pks_pkg::*;
  ;
  localparam int HOLD_T = 20;
  localparam int BLINK_T = 4;
  typedef struct packed {logic [31:0] m; logic [31:0] v;} pks_note_t;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic [3:0] pins = 4'h0;
  logic dp_rd = 1'b0;
  logic hsel, hwrite, hreadyout, hresp, hung, led1, led2;
  logic [7:0] haddr;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] hwdata, hrdata;
  logic [31:0] lfsr = 32'h3977;
  logic [7:0] gv [NUM_GAIN];
  pks_ring_t ring;
  pks_ring_t rg3 [3] = '{RING_ORANGE, RING_AMBER, RING_GREEN};
  pks_note_t notes [$];
  pks_note_t cur;
  int fail_count = 0;
  int checks_done = 0;
  always #2.5 clk = ~clk;
  pks_host_model u_pks_host_model (.clk(clk), .hready(hreadyout), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hung(hung));
  pks_top #(.HOLD(HOLD_T), .BLINK_HALF(BLINK_T)) u_pks_top (.clk(clk), .reset_n(reset_n),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .input_btn(pins[0]),
    .knob_btn(pins[1]), .knob_inc(pins[2]), .knob_dec(pins[3]), .first_channel_indicator(led1),
    .second_channel_indicator(led2), .ring(ring));
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [31:0] st(input logic [3:0] md, input logic [1:0] sg, input pks_ring_t rg,
    input logic [1:0] ld);
    return {22'h0, ld, rg, sg, md};
  endfunction
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] v);
    notes.push_back('{m, v});
    u_pks_host_model.xfer(1'b0, a, 32'h0);
  endtask
  // press one pin, then let sync and update settle
  task automatic push(input int b, input int len);
    @(posedge clk);
    pins[b] <= 1'b1;
    repeat (len) @(posedge clk);
    pins[b] <= 1'b0;
    repeat (8) @(posedge clk);
  endtask
  task automatic flash_check();
    int t;
    logic p;
    t = 0;
    p = led1;
    repeat (24) begin
      @(negedge clk);
      if (led1 !== p) t++;
      p = led1;
    end
    check("flash_edges", 32'(t >= 4), 32'h1);
  endtask
  // read data compared mid data phase, away from the updating edge
  always @(posedge clk) dp_rd <= reset_n && hsel && htrans[1] && !hwrite && hreadyout;
  always @(negedge clk) begin
    if (dp_rd) begin
      cur = notes.pop_front();
      check("hrdata", hrdata & cur.m, cur.v);
    end
  end
  always @(posedge clk) begin
    if (hung) begin
      fail_count++;
      conclude();
    end
  end
  initial begin
    repeat (6) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    rd(OFS_STATUS, 32'hffffffff, st(4'h0, 2'h0, RING_GREEN, 2'h1));
    rd(OFS_CTRL, 32'hffffffff, {24'h0, CTRL_RST});
    u_pks_host_model.xfer(1'b1, 8'h40, 32'hff);
    rd(8'h40, 32'hffffffff, 32'h0);
    for (int i = 0; i < NUM_GAIN; i++) begin
      lfsr = lfsr_next(lfsr);
      gv[i] = lfsr[7:0];
      u_pks_host_model.xfer(1'b1, OFS_GAIN0 + 8'(4 * i), lfsr);
      rd(OFS_GAIN0 + 8'(4 * i), 32'hffffffff, {24'h0, gv[i]});
    end
    push(2, 4);
    rd(OFS_GAIN0, 32'hff, {24'h0, gv[0]});
    push(0, 4);
    rd(OFS_STATUS, 32'h3ff, st(4'h1, 2'h0, RING_GREEN, 2'h1));
    push(0, 4);
    rd(OFS_STATUS, 32'h3ff, st(4'h3, 2'h0, RING_GREEN, 2'h2));
    push(1, 4);
    rd(OFS_STATUS, 32'h3ff, st(4'h1, 2'h0, RING_GREEN, 2'h1));
    u_pks_host_model.set_ctrl(8'h04);
    rd(OFS_STATUS, 32'h300, 32'h300);
    u_pks_host_model.set_ctrl(8'hf3);
    rd(OFS_STATUS, 32'h3ff, st(4'h1, 2'h0, RING_ORANGE, 2'h1));
    push(2, 4);
    rd(OFS_GAIN0, 32'hff, {24'h0, gv[0] == 8'hff ? 8'hff : gv[0] + 8'h1});
    push(3, 4);
    rd(OFS_GAIN0, 32'hff, {24'h0, gv[0] == 8'hff ? 8'hfe : gv[0]});
    push(1, HOLD_T + 6);
    rd(OFS_STATUS, 32'hff, st(4'h5, 2'h0, RING_ORANGE, 2'h0));
    flash_check();
    for (int k = 1; k < 4; k++) begin
      push(1, 4);
      rd(OFS_STATUS, 32'hff, st(4'h5, 2'(k % 3), rg3[k % 3], 2'h0));
    end
    push(1, 4);
    push(1, HOLD_T + 6);
    rd(OFS_STATUS, 32'h3ff, st(4'h1, 2'h0, RING_ORANGE, 2'h1));
    u_pks_host_model.set_ctrl(8'h03);
    push(1, HOLD_T + 6);
    for (int k = 1; k < 3; k++) begin
      push(1, 4);
      rd(OFS_STATUS, 32'hff, st(4'h5, 2'(k % 2), rg3[k % 2], 2'h0));
    end
    push(1, 4);
    push(0, 4);
    rd(OFS_STATUS, 32'h3ff, st(4'h3, 2'h0, RING_ORANGE, 2'h2));
    push(1, HOLD_T + 6);
    rd(OFS_STATUS, 32'hff, st(4'hf, 2'h0, RING_ORANGE, 2'h0));
    push(0, 4);
    push(1, HOLD_T + 6);
    push(1, 4);
    u_pks_host_model.set_ctrl(8'h02);
    rd(OFS_STATUS, 32'h3ff, st(4'h1, 2'h0, RING_GREEN, 2'h1));
    conclude();
  end
endmodule
`default_nettype wire
